/* File: logic/ptc_map.svh */
// Purpose: offsets, field positions, reset values and counts of the timer
// Assumes: 32-bit APB, one aligned word per register
// Notes: included by bare name
// Overview of operation
// - paired mode: run bit starts/stops 32-bit pair
// - single mode: run bit starts/stops 16-bit counter
// - idle-halt set stops counting in Idle mode
// - bits 14, 12..7, 2, 0 read zero, ignore writes
// - external source ignores gate bit, never gated
// - internal source: gate bit enables gated accumulation
// - prescale 00/01/10/11 gives 1, 8, 64, 256
// - pair bit joins low and high counters
// - source bit: external pin set, Fosc/2 clear
`ifndef PTC_MAP_SVH
`define PTC_MAP_SVH

// ****************************************
// register byte offsets
// ****************************************
`define PTC_OFS_CTRL 12'h000
`define PTC_OFS_LOW 12'h004
`define PTC_OFS_HIGH 12'h008
`define PTC_OFS_STATUS 12'h00c

// ****************************************
// control word field positions
// ****************************************
`define PTC_BIT_RUN 15
`define PTC_BIT_IDLE_HALT 13
`define PTC_BIT_GATE 6
`define PTC_BIT_PS_HI 5
`define PTC_BIT_PS_LO 4
`define PTC_BIT_PAIR 3
`define PTC_BIT_SRC 1
`define PTC_CTRL_MASK 16'ha07a
`define PTC_CTRL_RESET 16'h0000

// ****************************************
// status word field positions
// ****************************************
`define PTC_BIT_ST_ACTIVE 0
`define PTC_BIT_ST_IDLE 1
`define PTC_BIT_ST_GATE 2

// ****************************************
// prescaler terminal counts (ratio minus one)
// ****************************************
`define PTC_PS_LIM_1 8'h00
`define PTC_PS_LIM_8 8'h07
`define PTC_PS_LIM_64 8'h3f
`define PTC_PS_LIM_256 8'hff

`endif

/* File: logic/ptc_pin_sync.sv */
// Purpose: three-flop synchroniser with agreement filter and rise pulse
// Assumes: pin is asynchronous to pclk
// Notes: level moves only when the second and third flops agree
`timescale 1ns/1ps
module ptc_pin_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pin,
    output logic level,
    output logic rise
);
    import ptc_pkg::*;

    ptc_sync_st_t s_r;
    ptc_sync_st_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.ff1 = pin;
        s_nxt.ff2 = s_r.ff1;
        s_nxt.ff3 = s_r.ff2;
        s_nxt.rise = 1'b0;
        // ff1 feeds only ff2; the filter looks at ff2 and ff3
        if (s_r.ff2 == s_r.ff3) begin
            s_nxt.level = s_r.ff3;
            s_nxt.rise = s_r.ff3 & ~s_r.level;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign level = s_r.level;
    assign rise = s_r.rise;
endmodule

/* File: logic/ptc_pkg.sv */
// Purpose: types shared by the pairable timer control files
// Assumes: APB4 style slave with byte strobes
// Notes: constants live in ptc_map.svh
package ptc_pkg;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
        logic [3:0] pstrb;
    } ptc_apb_req_t;

    typedef struct packed {
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } ptc_apb_rsp_t;

    typedef struct packed {
        logic run_bit;
        logic idle_halt;
        logic gate_accumulate;
        logic [1:0] prescale_select;
        logic pair_join;
        logic clock_source_select;
    } ptc_ctrl_t;

    typedef struct packed {
        logic ff1;
        logic ff2;
        logic ff3;
        logic level;
        logic rise;
    } ptc_sync_st_t;

endpackage

/* File: logic/ptc_top.sv */
// Purpose: control of a timer that runs as 16-bit or as a 32-bit pair
// Assumes: idle_mode comes from the core on pclk; pins are asynchronous
// Notes: APB slave, one wait state on every access
`timescale 1ns/1ps
`include "ptc_map.svh"
module ptc_top (
    input wire logic pclk,
    input wire logic presetn,
    input ptc_pkg::ptc_apb_req_t apb_req,
    output ptc_pkg::ptc_apb_rsp_t apb_rsp,
    input wire logic idle_mode,
    input wire logic external_count_input,
    input wire logic gate_input,
    output logic [15:0] low_counter,
    output logic [15:0] high_counter,
    output logic count_active
);
    import ptc_pkg::*;

    typedef struct packed {
        ptc_ctrl_t ctrl;
        logic [15:0] low;
        logic [15:0] high;
        logic [7:0] presc;
        logic half;
        logic active;
        ptc_apb_rsp_t rsp;
    } ptc_state_t;

    ptc_state_t s_r;
    ptc_state_t s_nxt;
    logic ext_level;
    logic ext_rise;
    logic gate_level;

    // ****************************************
    // pin synchronisers
    // ****************************************
    ptc_pin_sync u_ext_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin(external_count_input),
        .level(ext_level),
        .rise(ext_rise)
    );

    ptc_pin_sync u_gate_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin(gate_input),
        .level(gate_level),
        .rise()
    );

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [7:0] ps_limit(input logic [1:0] sel);
        logic [7:0] lim;
        lim = `PTC_PS_LIM_1;
        case (sel)
            2'h0: lim = `PTC_PS_LIM_1;
            2'h1: lim = `PTC_PS_LIM_8;
            2'h2: lim = `PTC_PS_LIM_64;
            2'h3: lim = `PTC_PS_LIM_256;
            default: lim = `PTC_PS_LIM_1;
        endcase
        return lim;
    endfunction

    function automatic logic [15:0] ctrl_word(input ptc_ctrl_t c);
        logic [15:0] w;
        w = 16'h0000;
        w[`PTC_BIT_RUN] = c.run_bit;
        w[`PTC_BIT_IDLE_HALT] = c.idle_halt;
        w[`PTC_BIT_GATE] = c.gate_accumulate;
        w[`PTC_BIT_PS_HI:`PTC_BIT_PS_LO] = c.prescale_select;
        w[`PTC_BIT_PAIR] = c.pair_join;
        w[`PTC_BIT_SRC] = c.clock_source_select;
        return w;
    endfunction

    function automatic ptc_ctrl_t word_ctrl(input logic [15:0] w);
        ptc_ctrl_t c;
        c.run_bit = w[`PTC_BIT_RUN];
        c.idle_halt = w[`PTC_BIT_IDLE_HALT];
        c.gate_accumulate = w[`PTC_BIT_GATE];
        c.prescale_select = w[`PTC_BIT_PS_HI:`PTC_BIT_PS_LO];
        c.pair_join = w[`PTC_BIT_PAIR];
        c.clock_source_select = w[`PTC_BIT_SRC];
        return c;
    endfunction

    // byte-lane merge of write data over an old 16-bit value
    function automatic logic [15:0] merge16(
        input logic [15:0] old,
        input logic [15:0] wd,
        input logic [1:0] strb
    );
        logic [15:0] m;
        m = old;
        if (strb[0]) begin
            m[7:0] = wd[7:0];
        end
        if (strb[1]) begin
            m[15:8] = wd[15:8];
        end
        return m;
    endfunction

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        logic run_ok;
        logic src_tick;
        logic gated;
        logic tick_en;
        logic inc;
        logic access;
        logic [31:0] pair_sum;
        logic [15:0] wd;
        logic [15:0] cw;
        s_nxt = s_r;
        run_ok = 1'b0;
        src_tick = 1'b0;
        gated = 1'b0;
        tick_en = 1'b0;
        inc = 1'b0;
        pair_sum = 32'h0;
        wd = apb_req.pwdata[15:0];
        cw = 16'h0000;
        access = apb_req.psel & apb_req.penable & ~s_r.rsp.pready;
        s_nxt.rsp.pready = 1'b0;
        s_nxt.rsp.pslverr = 1'b0;

        // run bit starts or stops in either mode; idle may hold it
        run_ok = s_r.ctrl.run_bit &
            ~(s_r.ctrl.idle_halt & idle_mode);
        s_nxt.active = run_ok;

        // internal source runs at half the pclk rate
        s_nxt.half = run_ok ? ~s_r.half : 1'b0;
        src_tick = s_r.ctrl.clock_source_select ?
            ext_rise : s_r.half;

        // gating only applies to the internal source
        gated = ~s_r.ctrl.clock_source_select &
            s_r.ctrl.gate_accumulate;
        tick_en = run_ok & src_tick & (~gated | gate_level);

        if (!run_ok) begin
            s_nxt.presc = 8'h00;
        end else if (tick_en) begin
            if (s_r.presc >= ps_limit(s_r.ctrl.prescale_select)) begin
                s_nxt.presc = 8'h00;
                inc = 1'b1;
            end else begin
                s_nxt.presc = s_r.presc + 8'h01;
            end
        end

        if (inc) begin
            if (s_r.ctrl.pair_join) begin
                pair_sum = {s_r.high, s_r.low} + 32'h1;
                s_nxt.high = pair_sum[31:16];
                s_nxt.low = pair_sum[15:0];
            end else begin
                s_nxt.low = s_r.low + 16'h0001;
            end
        end

        // software writes override a same-cycle count
        if (access) begin
            s_nxt.rsp.pready = 1'b1;
            s_nxt.rsp.prdata = 32'h0;
            case (apb_req.paddr)
                `PTC_OFS_CTRL: begin
                    cw = ctrl_word(s_r.ctrl);
                    if (apb_req.pwrite) begin
                        cw = merge16(cw, wd, apb_req.pstrb[1:0]);
                        s_nxt.ctrl = word_ctrl(cw & `PTC_CTRL_MASK);
                    end else begin
                        s_nxt.rsp.prdata = {16'h0000, cw};
                    end
                end
                `PTC_OFS_LOW: begin
                    if (apb_req.pwrite) begin
                        s_nxt.low = merge16(s_r.low, wd, apb_req.pstrb[1:0]);
                    end else begin
                        s_nxt.rsp.prdata = {16'h0000, s_r.low};
                    end
                end
                `PTC_OFS_HIGH: begin
                    if (apb_req.pwrite) begin
                        s_nxt.high = merge16(s_r.high, wd, apb_req.pstrb[1:0]);
                    end else begin
                        s_nxt.rsp.prdata = {16'h0000, s_r.high};
                    end
                end
                `PTC_OFS_STATUS: begin
                    // read only; writes are dropped silently
                    if (!apb_req.pwrite) begin
                        s_nxt.rsp.prdata[`PTC_BIT_ST_ACTIVE] = s_r.active;
                        s_nxt.rsp.prdata[`PTC_BIT_ST_IDLE] = idle_mode;
                        s_nxt.rsp.prdata[`PTC_BIT_ST_GATE] = gate_level;
                    end
                end
                default: begin
                    s_nxt.rsp.pslverr = 1'b1;
                end
            endcase
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign apb_rsp = s_r.rsp;
    assign low_counter = s_r.low;
    assign high_counter = s_r.high;
    assign count_active = s_r.active;
endmodule

/* File: test/ptc_checker.sv */
// Purpose: port-level checks of the pairable timer control
// Assumes: control writes use all four byte strobes
// Notes: control word tracked from the edge a write is taken
`timescale 1ns/1ps
// ****
// checker
// ****
module ptc_checker (
    input wire logic pclk,
    input wire logic presetn,
    input ptc_pkg::ptc_apb_req_t apb_req,
    input ptc_pkg::ptc_apb_rsp_t apb_rsp,
    input wire logic idle_mode,
    input wire logic external_count_input,
    input wire logic gate_input,
    input wire logic [15:0] low_counter,
    input wire logic [15:0] high_counter,
    input wire logic count_active
);
    import ptc_pkg::*;
    logic [15:0] ctl_r;
    logic tk, wl, wh, go, gated;
    // taken edge, not pready edge: same edge the design updates
    assign tk = apb_req.psel && apb_req.penable && !apb_rsp.pready
        && apb_req.pwrite;
    assign wl = tk && apb_req.paddr == 12'h004;
    assign wh = tk && apb_req.paddr == 12'h008;
    assign go = ctl_r[15] && !(ctl_r[13] && idle_mode);
    assign gated = ctl_r[6] && !ctl_r[1];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ctl_r <= 16'h0000;
        else if (tk && apb_req.paddr == 12'h000)
            ctl_r <= apb_req.pwdata[15:0] & 16'ha07a;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    run_active_a: assert property (go |=> count_active)
        else $error("not active while run set");
    stop_inactive_a: assert property (
        !go |=> !count_active)
        else $error("active while run clear");
    idle_stop_a: assert property (
        ctl_r[15] && ctl_r[13] && idle_mode |=> !count_active)
        else $error("active in idle with halt set");
    ctrl_read_a: assert property (
        apb_rsp.pready && !apb_req.pwrite && apb_req.paddr == 12'h000
        |-> apb_rsp.prdata == {16'h0000, ctl_r})
        else $error("control read mismatch");
    // go is the run decision of this very edge; an external edge can
    // count on the first running edge, before count_active shows it
    low_hold_a: assert property (
        !go && !wl |=> $stable(low_counter))
        else $error("low counter moved while stopped");
    high_hold_a: assert property (
        !ctl_r[3] && !wh |=> $stable(high_counter))
        else $error("high counter moved unpaired");
    pair_carry_a: assert property (
        ctl_r[3] && !wl && !wh && low_counter == 16'hffff ##1
        low_counter == 16'h0000 |-> high_counter == $past(high_counter)
        + 16'h1)
        else $error("no carry into high counter");
    count_step_a: assert property (
        !wl |=> low_counter == $past(low_counter)
        || low_counter == $past(low_counter) + 16'h1)
        else $error("low counter jumped");
    gate_hold_a: assert property (
        (gated && !gate_input && !wl) [*8] |=> $stable(low_counter))
        else $error("counted with gate low");
endmodule

bind ptc_top ptc_checker chk_u (.pclk, .presetn, .apb_req, .apb_rsp,
    .idle_mode, .external_count_input, .gate_input, .low_counter,
    .high_counter, .count_active);

/* File: test/tb.sv */
// Purpose: directed bench of the pairable timer control
// Assumes: pclk 250 MHz, APB master holds until pready
// Notes: counts judged in ranges where the tick phase is free
`timescale 1ns/1ps
module tb;
    import ptc_pkg::*;
    // ****
    // signals and bus tasks
    // ****
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic idle_mode = 1'b0;
    logic external_count_input = 1'b0;
    logic gate_input = 1'b0;
    ptc_apb_req_t apb_req = '0;
    ptc_apb_rsp_t apb_rsp;
    logic [15:0] low_counter;
    logic [15:0] high_counter;
    logic count_active;
    logic [31:0] rd_d;
    logic rd_e;
    int n_mismatch = 0;
    int num_checks = 0;
    int nt[4] = '{1, 8, 64, 256};
    ptc_top dut_u (.pclk, .presetn, .apb_req, .apb_rsp, .idle_mode,
        .external_count_input, .gate_input, .low_counter, .high_counter,
        .count_active);
    always #2 pclk = ~pclk;
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic bad(input string m);
        n_mismatch++;
        $display("[ERR] %0t %s", $time, m);
    endtask
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int i;
        @(posedge pclk);
        apb_req <= '{1'b1, 1'b0, w, a, d, 4'hf};
        @(posedge pclk);
        apb_req.penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (apb_rsp.pready !== 1'b1 && i < 20);
        if (i >= 20)
            bad("no pready");
        rd_d = apb_rsp.prdata;
        rd_e = apb_rsp.pslverr;
        apb_req.psel <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a);
        xfer(1'b0, a, 32'h0);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e)
            bad($sformatf("got %h exp %h", g, e));
    endtask
    task automatic rng(input logic [15:0] g, input int lo, input int hi);
        num_checks++;
        if ($isunknown(g) || g < lo || g > hi)
            bad($sformatf("count %0d outside %0d..%0d", g, lo, hi));
    endtask
    // ****
    // scenarios
    // ****
    task automatic t_regs();
        rd(12'h000);
        chk(rd_d, 32'h0);
        wr(12'h000, 32'hffff_ffff);
        rd(12'h000);
        chk(rd_d, 32'h0000_a07a);
        wr(12'h000, 32'h0);
        rd(12'h010);
        chk({31'h0, rd_e}, 32'h1);
        $display("regs done");
    endtask
    task automatic t_ps();
        logic [31:0] g;
        for (int p = 0; p < 4; p++) begin
            wr(12'h004, 32'h0);
            wr(12'h000, 32'h8000 | (p << 4));
            wt(2048);
            wr(12'h000, 32'h0);
            rd(12'h004);
            rng(rd_d[15:0], 2048 / (2 * nt[p]) - 1,
                2060 / (2 * nt[p]) + 1);
            g = rd_d;
            wt(20);
            rd(12'h004);
            chk(rd_d, g);
        end
        $display("prescale done");
    endtask
    task automatic t_idle();
        wr(12'h004, 32'h0);
        idle_mode <= 1'b1;
        wr(12'h000, 32'ha000);
        wt(40);
        chk({31'h0, count_active}, 32'h0);
        rd(12'h00c);
        chk(rd_d, 32'h2);
        rd(12'h004);
        chk(rd_d, 32'h0);
        wr(12'h000, 32'h8000);
        wt(40);
        chk({31'h0, count_active}, 32'h1);
        rd(12'h00c);
        chk(rd_d, 32'h3);
        rd(12'h004);
        rng(rd_d[15:0], 15, 30);
        idle_mode <= 1'b0;
        wr(12'h000, 32'h0);
        $display("idle done");
    endtask
    task automatic t_gate();
        wr(12'h004, 32'h0);
        wr(12'h000, 32'h8040);
        wt(40);
        rd(12'h004);
        chk(rd_d, 32'h0);
        gate_input <= 1'b1;
        wt(40);
        rd(12'h004);
        rng(rd_d[15:0], 10, 26);
        gate_input <= 1'b0;
        wr(12'h004, 32'h0);
        wr(12'h000, 32'h8000);
        wt(40);
        rd(12'h004);
        rng(rd_d[15:0], 15, 30);
        wr(12'h000, 32'h0);
        $display("gate done");
    endtask
    task automatic t_ext();
        wr(12'h004, 32'h0);
        wr(12'h000, 32'h8042);
        wt(40);
        rd(12'h004);
        chk(rd_d, 32'h0);
        repeat (10) begin
            wt(6);
            external_count_input <= 1'b1;
            wt(6);
            external_count_input <= 1'b0;
        end
        wt(10);
        rd(12'h004);
        chk(rd_d, 32'ha);
        wr(12'h000, 32'h0);
        $display("external done");
    endtask
    task automatic t_pair();
        for (int j = 0; j < 2; j++) begin
            wr(12'h004, 32'hfff0);
            wr(12'h008, 32'h0012);
            wr(12'h000, j ? 32'h8000 : 32'h8008);
            wt(60);
            wr(12'h000, 32'h0);
            rd(12'h008);
            chk(rd_d, j ? 32'h12 : 32'h13);
            rd(12'h004);
            rng(rd_d[15:0], 10, 30);
        end
        $display("pair done");
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_ps();
        t_idle();
        t_gate();
        t_ext();
        t_pair();
        wrap_up();
    end
    initial begin
        #80000;
        bad("watchdog");
        wrap_up();
    end
endmodule
